// >>> hdl/rxsd_regs.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: Included by the receive SERDES control files
// Notes:   Definitions only
`ifndef RXSD_REGS_SVH
`define RXSD_REGS_SVH

`define RXSD_ADDR_CTL      6'h06
`define RXSD_ADDR_IEN      6'h07
`define RXSD_ADDR_STAT     6'h08
`define RXSD_ADDR_DATA_A   6'h09
`define RXSD_ADDR_DATA_B   6'h0B
`define RXSD_CTL_RESET     8'h03
`define RXSD_IEN_RESET     8'h00
`define RXSD_CTL_SERDES    3
`define RXSD_CTL_LEN_HI    2
`define RXSD_CTL_RSVD_MASK 8'h0F
`define RXSD_SPI_WR_BIT    7
`define RXSD_BYTE_BITS     4'h8

`endif

// >>> hdl/rxsd_pkg.sv
// Purpose: Shared types of the receive SERDES control block
// Assumes: Nothing
// Notes:   Offsets live in rxsd_regs.svh
package rxsd_pkg;
  typedef logic [7:0] rxsd_byte_t;
  typedef logic [2:0] rxsd_len_t;
  typedef enum logic [1:0]
  {
    SP_IDLE = 2'b00,
    SP_ADDR = 2'b01,
    SP_DATA = 2'b11
  } rxsd_spi_t;
endpackage : rxsd_pkg

// >>> hdl/rxsd_chan_if.sv
// Purpose: Carrier between the control top and one receive channel
// Assumes: Single clock domain
// Notes:   One instance per channel
`timescale 1ns/1ps
interface rxsd_chan_if;
  import rxsd_pkg::*;
  logic       bit_stb;
  logic       bit_valid;
  logic       bit_data;
  rxsd_len_t  eof_len;
  logic       serdes_en;
  logic       load;
  rxsd_byte_t load_byte;
  logic       load_all_valid;
  logic       eof;
  modport top  (output bit_stb, bit_valid, bit_data, eof_len, serdes_en,
                input load, load_byte, load_all_valid, eof);
  modport chan (input bit_stb, bit_valid, bit_data, eof_len, serdes_en,
                output load, load_byte, load_all_valid, eof);
endinterface : rxsd_chan_if

// >>> hdl/rxsd_chan.sv
// Purpose: Bit assembly and end-of-frame detection for one channel
// Assumes: bit_stb pulses once per bit time
// Notes:   load and eof are one-cycle pulses
`timescale 1ns/1ps
`include "rxsd_regs.svh"
module rxsd_chan
  import rxsd_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Channel carrier
  rxsd_chan_if.chan ch
);
  rxsd_byte_t sh_q;
  logic [3:0] nbits_q;
  logic [3:0] inv_q;
  logic       seen_q;
  logic [3:0] inv_d;
  logic       byte_done;
  logic       eof_hit;

  assign inv_d     = inv_q + 4'h1;
  assign byte_done = ch.bit_stb && ch.bit_valid && (nbits_q == `RXSD_BYTE_BITS - 4'h1);
  // Count of invalid bits must exceed the length
  assign eof_hit   = ch.bit_stb && !ch.bit_valid && seen_q
                     && (inv_d > {1'b0, ch.eof_len});

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      seen_q <= 1'b0;
      inv_q  <= 4'h0;
    end
    else if (ch.bit_stb)
    begin
      if (ch.bit_valid)
      begin
        seen_q <= 1'b1;
        inv_q  <= 4'h0;
      end
      else if (eof_hit)
      begin
        seen_q <= 1'b0;
        inv_q  <= 4'h0;
      end
      else if (seen_q)
        inv_q <= inv_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sh_q    <= 8'h00;
      nbits_q <= 4'h0;
    end
    else if (byte_done || eof_hit)
      nbits_q <= 4'h0;
    else if (ch.bit_stb && ch.bit_valid)
    begin
      sh_q    <= {sh_q[6:0], ch.bit_data};
      nbits_q <= nbits_q + 4'h1;
    end
  end

  // Bit-serial mode bypasses the data registers entirely
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ch.load           <= 1'b0;
      ch.load_byte      <= 8'h00;
      ch.load_all_valid <= 1'b0;
      ch.eof            <= 1'b0;
    end
    else
    begin
      ch.eof  <= eof_hit;
      ch.load <= ch.serdes_en && (byte_done || (eof_hit && nbits_q != 4'h0));
      if (byte_done)
      begin
        ch.load_byte      <= {sh_q[6:0], ch.bit_data};
        ch.load_all_valid <= 1'b1;
      end
      else if (eof_hit)
      begin
        ch.load_byte      <= sh_q;
        ch.load_all_valid <= 1'b0;
      end
    end
  end

  a_eof_after_valid: assert property (@(posedge ref_clk) disable iff (srst)
    eof_hit |-> seen_q) else $error("end of frame without a valid bit");
  a_eof_len_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (ch.bit_stb && !ch.bit_valid && seen_q && ch.eof_len == 3'h0) |=> ch.eof)
    else $error("zero length did not end frame at first invalid bit");
  a_eof_too_early: assert property (@(posedge ref_clk) disable iff (srst)
    eof_hit |-> inv_q >= {1'b0, ch.eof_len})
    else $error("end of frame before length expired");
  c_eof_seen: cover property (@(posedge ref_clk) ch.eof && ch.load);
endmodule : rxsd_chan

// >>> hdl/rxsd_top.sv
// Purpose: Receive SERDES control, end-of-frame and interrupt enables
// Assumes: SPI pins are synchronous to ref_clk, mode 0, MSB first
// Notes:   Frame = command byte {wr, x, addr[5:0]} then one data byte
`timescale 1ns/1ps
`include "rxsd_regs.svh"
// Function
// - Control bit 3 set selects byte-wide SERDES, clear selects bit-serial mode.
// - With SERDES on, payload moves a byte at a time through the data registers.
// - In bit-serial mode channel A data moves one bit at a time on the data and valid pins.
// - Control bits 2:0 set the tolerated run of invalid bit times before end of frame.
// - End of frame only after a valid bit and when invalid count exceeds the length.
// - Length zero ends the frame at the first invalid bit after valid data.
// - With SERDES on, end of frame moves pending data into the channel data register.
// - Enable bit 7 gates channel B underflow, a read of an empty data register.
// - Enable bit 6 gates channel B overflow, a load over unread data.
// - Enable bit 5 gates channel B end-of-frame interrupt while pending.
// - Reading the status register clears pending end-of-frame.
// - Enable bit 4 gates channel B full, raised on every load into its data register.
// - Enable bits 3 to 0 gate channel A underflow, overflow, end of frame and full.
// - Flow violation flag shows overflow or underflow and clears on status read.
module rxsd_top
  import rxsd_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // SPI register port
  input  wire logic spi_sck,
  input  wire logic spi_mosi,
  input  wire logic spi_ss_n,
  output logic      spi_miso,
  // Receiver bit stream, channels A and B
  input  wire logic [1:0] rx_bit_stb,
  input  wire logic [1:0] rx_bit_valid,
  input  wire logic [1:0] rx_bit_data,
  // Bit-serial pins, channel A
  output logic      serial_data_pin,
  output logic      serial_data_valid_pin,
  // Interrupt
  output logic      irq
);
  rxsd_byte_t  ctl_q;
  rxsd_byte_t  ien_q;
  rxsd_byte_t  data_q [2];
  logic [1:0]  full_q;
  logic [1:0]  allv_q;
  logic [1:0]  eofp_q;
  logic [1:0]  ovf_q;
  logic [1:0]  unf_q;
  rxsd_spi_t   sp_q;
  logic        sck_q;
  logic [2:0]  cnt_q;
  rxsd_byte_t  sh_q;
  rxsd_byte_t  out_q;
  logic        wr_q;
  logic [5:0]  addr_q;
  logic        rise;
  logic        fall;
  logic        byte_end;
  logic [5:0]  cmd_addr;
  logic        rd_cmd;
  logic        rd_stat;
  logic [1:0]  rd_data;
  logic [1:0]  load;
  logic [1:0]  eof;
  rxsd_byte_t  rd_val;
  rxsd_byte_t  stat;
  rxsd_byte_t  pend;

  rxsd_chan_if chif [2] ();

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      assign chif[g].bit_stb   = rx_bit_stb[g];
      assign chif[g].bit_valid = rx_bit_valid[g];
      assign chif[g].bit_data  = rx_bit_data[g];
      assign chif[g].eof_len   = ctl_q[`RXSD_CTL_LEN_HI:0];
      assign chif[g].serdes_en = ctl_q[`RXSD_CTL_SERDES];
      assign load[g]           = chif[g].load;
      assign eof[g]            = chif[g].eof;
      rxsd_chan u_chan
      (
        .ref_clk (ref_clk),
        .srst    (srst),
        .ch      (chif[g])
      );
      // Set wins over any clear in the same cycle
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          data_q[g] <= 8'h00;
          full_q[g] <= 1'b0;
          allv_q[g] <= 1'b0;
          eofp_q[g] <= 1'b0;
          ovf_q[g]  <= 1'b0;
          unf_q[g]  <= 1'b0;
        end
        else
        begin
          if (load[g])
          begin
            data_q[g] <= chif[g].load_byte;
            allv_q[g] <= chif[g].load_all_valid;
          end
          full_q[g] <= load[g] || (full_q[g] && !rd_data[g]);
          eofp_q[g] <= eof[g] || (eofp_q[g] && !rd_stat);
          ovf_q[g]  <= (load[g] && full_q[g] && !rd_data[g])
                       || (ovf_q[g] && !rd_stat);
          unf_q[g]  <= (rd_data[g] && !full_q[g]) || (unf_q[g] && !rd_stat);
        end
      end
    end
  endgenerate

  // Bit-serial output mirrors channel A, host owns the timing
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      serial_data_pin       <= 1'b0;
      serial_data_valid_pin <= 1'b0;
    end
    else if (!ctl_q[`RXSD_CTL_SERDES] && rx_bit_stb[0])
    begin
      serial_data_pin       <= rx_bit_data[0];
      serial_data_valid_pin <= rx_bit_valid[0];
    end
  end

  // SPI framing; sck sampled, so it must stay well below ref_clk/4
  assign rise     = spi_sck && !sck_q && !spi_ss_n;
  assign fall     = !spi_sck && sck_q && !spi_ss_n;
  assign byte_end = rise && (cnt_q == 3'h7);
  assign cmd_addr = {sh_q[4:0], spi_mosi};
  assign rd_cmd   = byte_end && (sp_q == SP_ADDR) && !sh_q[`RXSD_SPI_WR_BIT - 1];
  assign rd_stat  = rd_cmd && (cmd_addr == `RXSD_ADDR_STAT);
  assign rd_data  = {rd_cmd && (cmd_addr == `RXSD_ADDR_DATA_B),
                     rd_cmd && (cmd_addr == `RXSD_ADDR_DATA_A)};
  assign stat     = {allv_q[1], ovf_q[1] | unf_q[1], eofp_q[1], full_q[1],
                     allv_q[0], ovf_q[0] | unf_q[0], eofp_q[0], full_q[0]};

  always_comb
  begin
    case (cmd_addr)
      `RXSD_ADDR_CTL:    rd_val = ctl_q;
      `RXSD_ADDR_IEN:    rd_val = ien_q;
      `RXSD_ADDR_STAT:   rd_val = stat;
      `RXSD_ADDR_DATA_A: rd_val = data_q[0];
      `RXSD_ADDR_DATA_B: rd_val = data_q[1];
      default:           rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sp_q   <= SP_IDLE;
      sck_q  <= 1'b0;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      wr_q   <= 1'b0;
      addr_q <= 6'h00;
    end
    else
    begin
      sck_q <= spi_sck;
      if (spi_ss_n)
      begin
        sp_q  <= SP_IDLE;
        cnt_q <= 3'h0;
      end
      else
      begin
        if (sp_q == SP_IDLE)
          sp_q <= SP_ADDR;
        if (rise)
        begin
          sh_q  <= {sh_q[6:0], spi_mosi};
          cnt_q <= cnt_q + 3'h1;
        end
        if (byte_end && sp_q == SP_ADDR)
        begin
          // Bit 7 of the command: 1 = write
          wr_q   <= sh_q[`RXSD_SPI_WR_BIT - 1];
          addr_q <= cmd_addr;
          sp_q   <= SP_DATA;
        end
      end
    end
  end

  // Write path; reserved control bits are not stored (host writes zeros)
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctl_q <= `RXSD_CTL_RESET;
      ien_q <= `RXSD_IEN_RESET;
    end
    else if (byte_end && sp_q == SP_DATA && wr_q)
    begin
      if (addr_q == `RXSD_ADDR_CTL)
        ctl_q <= {sh_q[6:0], spi_mosi} & `RXSD_CTL_RSVD_MASK;
      if (addr_q == `RXSD_ADDR_IEN)
        ien_q <= {sh_q[6:0], spi_mosi};
    end
  end

  // Read byte captured at command end; the fall after that rise presents bit 7,
  // so a mode 0 host sees every bit before the rise that samples it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      out_q    <= 8'h00;
      spi_miso <= 1'b0;
    end
    else if (rd_cmd)
      out_q <= rd_val;
    else if (fall && sp_q == SP_DATA)
    begin
      out_q    <= {out_q[6:0], 1'b0};
      spi_miso <= out_q[7];
    end
  end

  assign pend = {unf_q[1], ovf_q[1], eofp_q[1], full_q[1],
                 unf_q[0], ovf_q[0], eofp_q[0], full_q[0]};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(pend & ien_q);
  end

  a_irq_follows: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 irq == |($past(pend) & $past(ien_q))) else $error("irq mismatch");
  a_stat_clears_eof: assert property (@(posedge ref_clk) disable iff (srst)
    (rd_stat && !eof[1]) |=> !eofp_q[1]) else $error("eof B not cleared");
  a_overflow_set: assert property (@(posedge ref_clk) disable iff (srst)
    (load[1] && full_q[1] && !rd_data[1]) |=> ovf_q[1] && stat[6])
    else $error("overflow B missed");
  a_underflow_set: assert property (@(posedge ref_clk) disable iff (srst)
    (rd_data[0] && !full_q[0]) |=> unf_q[0] && stat[2])
    else $error("underflow A missed");
  a_full_on_load: assert property (@(posedge ref_clk) disable iff (srst)
    load[1] |=> full_q[1] && stat[4]) else $error("full B missed");
  a_serial_no_load: assert property (@(posedge ref_clk) disable iff (srst)
    !ctl_q[`RXSD_CTL_SERDES] && !$past(ctl_q[`RXSD_CTL_SERDES]) |-> load == 2'b00)
    else $error("load in bit-serial mode");
  a_eof_en_gate: assert property (@(posedge ref_clk) disable iff (srst)
    (eofp_q[1] && ien_q[5]) |=> irq) else $error("eof B irq missing");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
    ctl_q[7:4] == 4'h0) else $error("reserved control bits set");
  c_eof_irq: cover property (@(posedge ref_clk) eofp_q[0] && irq);
  c_overflow: cover property (@(posedge ref_clk) ovf_q[1]);
  c_serial: cover property (@(posedge ref_clk) serial_data_valid_pin ##1 !serial_data_valid_pin);
endmodule : rxsd_top

// >>> testbench/rxsd_host_model.sv
// Purpose: Host SPI master model for the receive SERDES control block
// Assumes: Mode 0, command byte then data byte, MSB first
// Notes:   Sck high 2 and low 3 ref_clk cycles
`timescale 1ns/1ps
module rxsd_host_model
  import rxsd_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // SPI pins
  output logic      spi_sck,
  output logic      spi_mosi,
  output logic      spi_ss_n,
  input  wire logic spi_miso
);
  initial
  begin
    spi_sck  = 1'b0;
    spi_mosi = 1'b0;
    spi_ss_n = 1'b1;
  end

  // Whole bytes only, host keeps all frame timing
  task automatic xfer(input rxsd_byte_t cmd, input rxsd_byte_t wdat, output rxsd_byte_t rdat);
    logic [15:0] sh;
    sh   = {cmd, wdat};
    rdat = 8'h00;
    @(posedge ref_clk);
    spi_ss_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge ref_clk);
      spi_sck  <= 1'b0;
      spi_mosi <= sh[i];
      repeat (2) @(posedge ref_clk);
      // Sampled off the edge at which miso may move
      @(negedge ref_clk);
      if (i < 8)
        rdat[i] = spi_miso;
      @(posedge ref_clk);
      spi_sck <= 1'b1;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    spi_sck  <= 1'b0;
    // Stale bit inverted so it cannot pass for data
    spi_mosi <= ~spi_mosi;
    repeat (2) @(posedge ref_clk);
    spi_ss_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : xfer
endmodule : rxsd_host_model

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the receive SERDES control block
// Assumes: Host model drives the SPI pins
// Notes:   Each scenario starts from a fresh reset
`timescale 1ns/1ps
module tb;
  import rxsd_pkg::*;
  logic       ref_clk;
  logic       srst;
  logic       spi_sck;
  logic       spi_mosi;
  logic       spi_ss_n;
  logic       spi_miso;
  logic [1:0] rx_bit_stb;
  logic [1:0] rx_bit_valid;
  logic [1:0] rx_bit_data;
  logic       serial_data_pin;
  logic       serial_data_valid_pin;
  logic       irq;
  int         n_errors;
  int         check_count;

  rxsd_top dut_u (.ref_clk(ref_clk), .srst(srst), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_ss_n(spi_ss_n), .spi_miso(spi_miso), .rx_bit_stb(rx_bit_stb),
    .rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data), .serial_data_pin(serial_data_pin),
    .serial_data_valid_pin(serial_data_valid_pin), .irq(irq));
  rxsd_host_model host_u (.ref_clk(ref_clk), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_ss_n(spi_ss_n), .spi_miso(spi_miso));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic cmp(input rxsd_byte_t got, input rxsd_byte_t exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t pin %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic do_reset();
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
  endtask : do_reset

  task automatic wr(input logic [5:0] a, input rxsd_byte_t d);
    rxsd_byte_t r;
    host_u.xfer({2'b10, a}, d, r);
  endtask : wr

  // Masked read, mask 00 is a plain access
  task automatic rd(input logic [5:0] a, input rxsd_byte_t m, input rxsd_byte_t e);
    rxsd_byte_t r;
    host_u.xfer({2'b00, a}, 8'h00, r);
    if (m != 8'h00)
      cmp(r & m, e);
  endtask : rd

  // Sends n bits MSB first from v and d, then lets loads and irq land
  task automatic bits(input int ch, input rxsd_byte_t v, input rxsd_byte_t d, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      @(posedge ref_clk);
      rx_bit_stb[ch]   <= 1'b1;
      rx_bit_valid[ch] <= v[i];
      rx_bit_data[ch]  <= d[i];
      @(posedge ref_clk);
      rx_bit_stb[ch]   <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask : bits

  task automatic chk_irq(input logic e);
    @(negedge ref_clk);
    cmp_bit(irq, e);
  endtask : chk_irq

  task automatic t_regs();
    do_reset();
    rd(6'h06, 8'hFF, 8'h03);
    rd(6'h07, 8'hFF, 8'h00);
    rd(6'h3F, 8'hFF, 8'h00);
    wr(6'h06, 8'h0B);
    rd(6'h06, 8'hFF, 8'h0B);
    wr(6'h07, 8'hA5);
    rd(6'h07, 8'hFF, 8'hA5);
  endtask : t_regs

  task automatic t_serial();
    do_reset();
    for (int k = 1; k >= 0; k--)
    begin
      @(posedge ref_clk);
      rx_bit_stb   <= 2'b01;
      rx_bit_valid <= 2'b01;
      rx_bit_data  <= {1'b0, k[0]};
      @(posedge ref_clk);
      rx_bit_stb   <= 2'b00;
      @(negedge ref_clk);
      cmp_bit(serial_data_valid_pin, 1'b1);
      cmp_bit(serial_data_pin, k[0]);
    end
    rd(6'h08, 8'h11, 8'h00);
  endtask : t_serial

  task automatic t_eof_zero();
    do_reset();
    wr(6'h06, 8'h08);
    wr(6'h07, 8'h02);
    bits(0, 8'hE0, 8'hA0, 4);
    cmp_bit(serial_data_valid_pin, 1'b0);
    chk_irq(1'b1);
    rd(6'h08, 8'hFF, 8'h03);
    chk_irq(1'b0);
    rd(6'h09, 8'hFF, 8'h05);
  endtask : t_eof_zero

  task automatic t_eof_len();
    do_reset();
    wr(6'h06, 8'h0A);
    wr(6'h07, 8'h20);
    // Invalid bits before any valid one never end a frame
    bits(1, 8'h00, 8'h00, 3);
    bits(1, 8'h80, 8'h80, 3);
    chk_irq(1'b0);
    bits(1, 8'h00, 8'h00, 1);
    chk_irq(1'b1);
    rd(6'h08, 8'hF0, 8'h30);
    chk_irq(1'b0);
    rd(6'h0B, 8'hFF, 8'h01);
  endtask : t_eof_len

  task automatic t_flow();
    do_reset();
    wr(6'h06, 8'h0F);
    wr(6'h07, 8'h10);
    bits(1, 8'hFF, 8'hA5, 8);
    chk_irq(1'b1);
    rd(6'h08, 8'hF0, 8'h90);
    rd(6'h0B, 8'hFF, 8'hA5);
    chk_irq(1'b0);
    wr(6'h07, 8'h40);
    bits(1, 8'hFF, 8'h3C, 8);
    chk_irq(1'b0);
    bits(1, 8'hFF, 8'hC3, 8);
    chk_irq(1'b1);
    rd(6'h08, 8'h70, 8'h50);
    chk_irq(1'b0);
    rd(6'h08, 8'h40, 8'h00);
    wr(6'h07, 8'h80);
    rd(6'h0B, 8'h00, 8'h00);
    rd(6'h0B, 8'h00, 8'h00);
    chk_irq(1'b1);
    rd(6'h08, 8'h40, 8'h40);
  endtask : t_flow

  task automatic t_under_a();
    do_reset();
    wr(6'h06, 8'h08);
    wr(6'h07, 8'h08);
    rd(6'h09, 8'h00, 8'h00);
    chk_irq(1'b1);
    wr(6'h07, 8'h00);
    chk_irq(1'b0);
  endtask : t_under_a

  task automatic final_report();
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    n_errors     = 0;
    check_count  = 0;
    srst         = 1'b1;
    rx_bit_stb   = 2'b00;
    rx_bit_valid = 2'b00;
    rx_bit_data  = 2'b00;
    t_regs();
    t_serial();
    t_eof_zero();
    t_eof_len();
    t_flow();
    t_under_a();
    final_report();
  end

  // Runs take about 2900 cycles, so this only fires on a hang
  initial
  begin
    #400000;
    n_errors++;
    final_report();
  end
endmodule : tb
